/* hw/rtap_pkg.sv */
// constants and types for the retimer adaptation and pattern control slice
package rtap_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_EQ_INDEX    = 8'h13;
	localparam logic [7:0] IDX_LOCK_ADAPT  = 8'h2F;
	localparam logic [7:0] IDX_EYE_PRBS    = 8'h30;
	localparam logic [7:0] IDX_ADAPT_MODE  = 8'h31;
	localparam logic [7:0] IDX_EYE_INT_CFG = 8'h36;
	localparam logic [7:0] IDX_EYE_LIMIT   = 8'h76;

	// reset values
	localparam logic [7:0] RST_EQ_INDEX    = 8'h00;
	localparam logic [7:0] RST_LOCK_ADAPT  = 8'h06;
	localparam logic [7:0] RST_EYE_PRBS    = 8'h00;
	localparam logic [7:0] RST_ADAPT_MODE  = 8'h20;
	localparam logic [7:0] RST_EYE_INT_CFG = 8'h00;
	localparam logic [7:0] RST_EYE_LIMIT   = 8'h11;

	// lock and adapt control fields
	localparam int RATE_MSB       = 7;
	localparam int RATE_LSB       = 4;
	localparam int EQ_OVR_BIT     = 3;
	localparam int PPM_EN_BIT     = 2;
	localparam int FLD_DIS_BIT    = 1;
	localparam int ADAPT_GO_BIT   = 0;
	// eye flags and pattern control fields
	localparam int RANGE_ERR_BIT  = 5;
	localparam int EYE_FLAG_BIT   = 4;
	localparam int PAT_CLK_EN_BIT = 3;
	localparam int PAT_SEL_MSB    = 1;
	localparam int PAT_SEL_LSB    = 0;
	// adaptation mode fields
	localparam int AD_MODE_MSB    = 6;
	localparam int AD_MODE_LSB    = 5;
	localparam int MERIT_MSB      = 4;
	localparam int MERIT_LSB      = 3;
	// other fields
	localparam int EQ_IDX_MSB     = 4;
	localparam int EYE_INT_EN_BIT = 6;
	localparam int LIM_H_MSB      = 7;
	localparam int LIM_H_LSB      = 4;
	localparam int LIM_V_MSB      = 3;
	localparam int LIM_V_LSB      = 0;

	localparam logic [1:0] REF_MODE_FLD = 2'h3;

	localparam logic [1:0] AD_NONE    = 2'h0;
	localparam logic [1:0] AD_CTLE    = 2'h1;
	localparam logic [1:0] AD_OPT_DFE = 2'h2;
	localparam logic [1:0] AD_LOCK    = 2'h3;
	localparam logic [1:0] MERIT_BAD  = 2'h0;
	localparam logic [1:0] MERIT_HEO  = 2'h1;
	localparam logic [1:0] MERIT_VEO  = 2'h2;

	localparam logic [1:0] PAT_7  = 2'h0;
	localparam logic [1:0] PAT_9  = 2'h1;
	localparam logic [1:0] PAT_15 = 2'h2;
	localparam logic [1:0] PAT_31 = 2'h3;
	localparam logic [30:0] PAT_SEED = 31'h7FFFFFFF;

	typedef enum logic [3:0] {
		AD_IDLE  = 4'h1,
		AD_CTLE1 = 4'h2,
		AD_DFE   = 4'h4,
		AD_CTLE2 = 4'h8
	} rtap_adapt_e;
endpackage

/* hw/rtap_pat_if.sv */
// link between the register slice and the pattern engine
`timescale 1ns/100ps
`default_nettype none
interface rtap_pat_if;
	logic       clk_en;
	logic [1:0] sel;
	logic       rx_bit;
	logic       tx_bit;
	logic       err;
	modport ctrl   (output clk_en, output sel, output rx_bit, input tx_bit, input err);
	modport engine (input clk_en, input sel, input rx_bit, output tx_bit, output err);
endinterface
`default_nettype wire

/* hw/rtap_pat_engine.sv */
// pattern generator and self-synchronising checker
`timescale 1ns/100ps
`default_nettype none
module rtap_pat_engine (
	input  wire logic       pclk,
	input  wire logic       presetn,
	rtap_pat_if.engine      pat
);
	logic [30:0] gen_q;
	logic [30:0] chk_q;
	logic        en_q;
	logic [1:0]  sel_q;
	logic        tx_q;
	logic        err_q;
	logic        restart;

	function automatic logic fb(input logic [30:0] s, input logic [1:0] sel);
		case (sel)
			rtap_pkg::PAT_7:  fb = s[6] ^ s[5];
			rtap_pkg::PAT_9:  fb = s[8] ^ s[4];
			rtap_pkg::PAT_15: fb = s[14] ^ s[13];
			default:          fb = s[30] ^ s[27];
		endcase
	endfunction

	// any toggle of the enable or change of pattern reseeds both machines
	assign restart = (pat.clk_en != en_q) || (pat.sel != sel_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q  <= 1'b0;
			sel_q <= 2'h0;
		end else begin
			en_q  <= pat.clk_en;
			sel_q <= pat.sel;
		end
	end

	// with the enable low both shift registers and the output bit are frozen and the error flag is cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_q <= rtap_pkg::PAT_SEED;
			chk_q <= rtap_pkg::PAT_SEED;
			tx_q  <= 1'b0;
			err_q <= 1'b0;
		end else if (restart) begin // R8
			gen_q <= rtap_pkg::PAT_SEED;
			chk_q <= rtap_pkg::PAT_SEED;
			err_q <= 1'b0;
		end else if (pat.clk_en) begin // R7
			gen_q <= {gen_q[29:0], fb(gen_q, pat.sel)}; // R9 R10
			tx_q  <= fb(gen_q, pat.sel);
			chk_q <= {chk_q[29:0], pat.rx_bit};
			err_q <= pat.rx_bit ^ fb(chk_q, pat.sel);
		end else begin
			err_q <= 1'b0;
		end
	end

	assign pat.tx_bit = tx_q;
	assign pat.err    = err_q;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_gate_frozen: assert property ( // R7
		!pat.clk_en && !restart |=> $stable(gen_q) && !err_q)
		else $error("pattern engine advanced with its clock disabled");
	chk_toggle_reseed: assert property ( // R8
		restart |=> gen_q == rtap_pkg::PAT_SEED && chk_q == rtap_pkg::PAT_SEED)
		else $error("pattern machines not reseeded on enable toggle");
	chk_prbs7_taps: assert property ( // R9
		pat.clk_en && !restart && pat.sel == rtap_pkg::PAT_7
		|=> gen_q[0] == ($past(gen_q[6]) ^ $past(gen_q[5])))
		else $error("prbs7 feedback wrong");
	chk_prbs9_taps: assert property ( // R10
		pat.clk_en && !restart && pat.sel == rtap_pkg::PAT_9
		|=> gen_q[0] == ($past(gen_q[8]) ^ $past(gen_q[4])))
		else $error("prbs9 feedback wrong");
endmodule
`default_nettype wire

/* hw/rtap_regs.sv */
// retimer channel lock, adaptation, eye flag and pattern control registers
//
// What this block does
// R1 - override makes index register pick equalizer setting
// R2 - ppm check enable adds lock qualifier
// R3 - in reference mode 3, bit disables frequency-lock
// R4 - adaptation start bit launches run, self-clears
// R5 - low eye opening sets flag when enabled
// R6 - eye flag sticks until read clears it
// R7 - pattern clock enable gates generator and checker
// R8 - toggling pattern clock enable restarts both machines
// R9 - select 00 gives prbs7, 11 prbs31
// R10 - select 01 gives prbs9, 10 prbs15
// R11 - mode 00 none, 01 ctle, 10 ctle-dfe-ctle
// R12 - mode 11 ctle to lock, dfe, then eq
// R13 - merit field picks horizontal, vertical, both; 00 invalid
`timescale 1ns/100ps
`default_nettype none
module rtap_regs (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [1:0]  ref_mode,
	input  wire logic        cdr_phase_lock,
	input  wire logic        ppm_check_pass,
	input  wire logic        freq_lock_ok,
	input  wire logic [4:0]  adapt_eq_index,
	input  wire logic        ctle_optimal,
	input  wire logic        dfe_done,
	input  wire logic [7:0]  horizontal_eye_opening,
	input  wire logic [7:0]  vertical_eye_opening,
	input  wire logic        eye_meas_valid,
	input  wire logic        eye_monitor_range_error,
	input  wire logic        pattern_rx_bit,
	output logic      [4:0]  eq_index_q,
	output logic      [3:0]  rate_ctrl_q,
	output logic             cdr_lock_q,
	output logic             freq_lock_detection_q,
	output logic             ctle_run_q,
	output logic             dfe_run_q,
	output logic             adapt_busy_q,
	output logic             merit_use_heo_q,
	output logic             merit_use_veo_q,
	output logic             pattern_tx_bit,
	output logic             pattern_err
);
	logic [7:0]  eq_idx_reg_q;
	logic [7:0]  lock_reg_q;
	logic [7:0]  prbs_reg_q;
	logic [7:0]  mode_reg_q;
	logic [7:0]  int_cfg_q;
	logic [7:0]  limit_q;
	logic        adapt_start_q;
	logic        eye_flag_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic [7:0]  rd_byte;
	logic        hit;
	logic        setup;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  idx;
	logic        rd_eye;
	logic        eye_low;
	logic        fld_active;
	logic [1:0]  ad_mode;
	logic [1:0]  merit;
	logic        start_ok;
	rtap_pkg::rtap_adapt_e state_q;
	rtap_pkg::rtap_adapt_e state_d;

	rtap_pat_if pat ();

	rtap_pat_engine u_pat (
		.pclk    (pclk),
		.presetn (presetn),
		.pat     (pat.engine)
	);

	assign idx     = paddr[9:2];
	assign setup   = psel && !penable;
	assign wr_en   = psel && penable && pready_q && pwrite && pstrb[0];
	assign rd_en   = psel && penable && pready_q && !pwrite;
	assign rd_eye  = rd_en && idx == rtap_pkg::IDX_EYE_PRBS && !pslverr_q;
	assign ad_mode = mode_reg_q[rtap_pkg::AD_MODE_MSB:rtap_pkg::AD_MODE_LSB];
	assign merit   = mode_reg_q[rtap_pkg::MERIT_MSB:rtap_pkg::MERIT_LSB];

	always_comb begin
		hit     = 1'b1;
		rd_byte = 8'h00;
		case (idx)
			rtap_pkg::IDX_EQ_INDEX:    rd_byte = eq_idx_reg_q;
			rtap_pkg::IDX_LOCK_ADAPT:  rd_byte = {lock_reg_q[7:1], adapt_start_q};
			rtap_pkg::IDX_EYE_PRBS:    rd_byte = {prbs_reg_q[7:6], eye_monitor_range_error,
			                                      eye_flag_q, prbs_reg_q[3:0]};
			rtap_pkg::IDX_ADAPT_MODE:  rd_byte = mode_reg_q;
			rtap_pkg::IDX_EYE_INT_CFG: rd_byte = int_cfg_q;
			rtap_pkg::IDX_EYE_LIMIT:   rd_byte = limit_q;
			default:                   hit = 1'b0;
		endcase
		if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) begin
			hit = 1'b0;
		end
	end

	// answer is decided in setup so every bus output comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup && !hit;
			if (setup && !pwrite) begin
				prdata_q <= {24'h000000, hit ? rd_byte : 8'h00};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eq_idx_reg_q <= rtap_pkg::RST_EQ_INDEX;
			lock_reg_q   <= rtap_pkg::RST_LOCK_ADAPT;
			prbs_reg_q   <= rtap_pkg::RST_EYE_PRBS;
			mode_reg_q   <= rtap_pkg::RST_ADAPT_MODE;
			int_cfg_q    <= rtap_pkg::RST_EYE_INT_CFG;
			limit_q      <= rtap_pkg::RST_EYE_LIMIT;
		end else if (wr_en && !pslverr_q) begin
			case (idx)
				rtap_pkg::IDX_EQ_INDEX:    eq_idx_reg_q <= pwdata[7:0];
				rtap_pkg::IDX_LOCK_ADAPT:  lock_reg_q   <= {pwdata[7:1], 1'b0};
				rtap_pkg::IDX_EYE_PRBS:    prbs_reg_q   <= {pwdata[7:6], 2'h0, pwdata[3:0]};
				rtap_pkg::IDX_ADAPT_MODE:  mode_reg_q   <= pwdata[7:0];
				rtap_pkg::IDX_EYE_INT_CFG: int_cfg_q    <= pwdata[7:0];
				rtap_pkg::IDX_EYE_LIMIT:   limit_q      <= pwdata[7:0];
				default:                   limit_q      <= limit_q;
			endcase
		end
	end

	// start bit reads 1 for exactly one cycle after the write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adapt_start_q <= 1'b0;
		end else begin
			adapt_start_q <= wr_en && !pslverr_q && idx == rtap_pkg::IDX_LOCK_ADAPT
			                 && pwdata[rtap_pkg::ADAPT_GO_BIT]; // R4
		end
	end

	// limits count in steps of eight eye-opening units
	assign eye_low = eye_meas_valid && int_cfg_q[rtap_pkg::EYE_INT_EN_BIT]
		&& ((horizontal_eye_opening
		     < {1'b0, limit_q[rtap_pkg::LIM_H_MSB:rtap_pkg::LIM_H_LSB], 3'h0})
		 || (vertical_eye_opening
		     < {1'b0, limit_q[rtap_pkg::LIM_V_MSB:rtap_pkg::LIM_V_LSB], 3'h0}));

	// a new low-eye event beats a clearing read in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eye_flag_q <= 1'b0;
		end else if (eye_low) begin
			eye_flag_q <= 1'b1; // R5
		end else if (rd_eye) begin
			eye_flag_q <= 1'b0; // R6
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eq_index_q  <= 5'h00;
			rate_ctrl_q <= 4'h0;
		end else begin
			eq_index_q  <= lock_reg_q[rtap_pkg::EQ_OVR_BIT] ?
			               eq_idx_reg_q[rtap_pkg::EQ_IDX_MSB:0] : adapt_eq_index; // R1
			rate_ctrl_q <= lock_reg_q[rtap_pkg::RATE_MSB:rtap_pkg::RATE_LSB];
		end
	end

	// outside reference mode 3 frequency-lock detection stays on
	assign fld_active = (ref_mode == rtap_pkg::REF_MODE_FLD) ?
	                    !lock_reg_q[rtap_pkg::FLD_DIS_BIT] : 1'b1; // R3

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cdr_lock_q            <= 1'b0;
			freq_lock_detection_q <= 1'b0;
		end else begin
			freq_lock_detection_q <= fld_active;
			cdr_lock_q <= cdr_phase_lock
			           && (!lock_reg_q[rtap_pkg::PPM_EN_BIT] || ppm_check_pass) // R2
			           && (!fld_active || freq_lock_ok);
		end
	end

	// an invalid merit code or mode 00 leaves the start ignored
	assign start_ok = adapt_start_q && ad_mode != rtap_pkg::AD_NONE
	                  && merit != rtap_pkg::MERIT_BAD; // R11 R13

	always_comb begin
		state_d = state_q;
		case (state_q)
			rtap_pkg::AD_IDLE: begin
				if (start_ok) begin
					state_d = rtap_pkg::AD_CTLE1;
				end
			end
			rtap_pkg::AD_CTLE1: begin
				case (ad_mode)
					rtap_pkg::AD_CTLE: begin
						if (ctle_optimal) state_d = rtap_pkg::AD_IDLE; // R11
					end
					rtap_pkg::AD_OPT_DFE: begin
						if (ctle_optimal) state_d = rtap_pkg::AD_DFE; // R11
					end
					rtap_pkg::AD_LOCK: begin
						if (cdr_lock_q) state_d = rtap_pkg::AD_DFE; // R12
					end
					default: state_d = rtap_pkg::AD_IDLE;
				endcase
			end
			rtap_pkg::AD_DFE: begin
				if (dfe_done) state_d = rtap_pkg::AD_CTLE2;
			end
			rtap_pkg::AD_CTLE2: begin
				if (ctle_optimal) state_d = rtap_pkg::AD_IDLE; // R12
			end
			default: state_d = rtap_pkg::AD_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q         <= rtap_pkg::AD_IDLE;
			ctle_run_q      <= 1'b0;
			dfe_run_q       <= 1'b0;
			adapt_busy_q    <= 1'b0;
			merit_use_heo_q <= 1'b0;
			merit_use_veo_q <= 1'b0;
		end else begin
			state_q         <= state_d;
			ctle_run_q      <= state_d == rtap_pkg::AD_CTLE1 || state_d == rtap_pkg::AD_CTLE2;
			dfe_run_q       <= state_d == rtap_pkg::AD_DFE;
			adapt_busy_q    <= state_d != rtap_pkg::AD_IDLE;
			merit_use_heo_q <= merit[0]; // R13
			merit_use_veo_q <= merit[1]; // R13
		end
	end

	assign pat.clk_en = prbs_reg_q[rtap_pkg::PAT_CLK_EN_BIT]; // R7 R8
	assign pat.sel    = prbs_reg_q[rtap_pkg::PAT_SEL_MSB:rtap_pkg::PAT_SEL_LSB]; // R9 R10
	assign pat.rx_bit = pattern_rx_bit;

	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign pattern_tx_bit = pat.tx_bit;
	assign pattern_err    = pat.err;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence start_write;
		wr_en && !pslverr_q && idx == rtap_pkg::IDX_LOCK_ADAPT && pwdata[0];
	endsequence
	sequence start_pulse;
		adapt_start_q ##1 !adapt_start_q;
	endsequence
	// a read with no new low-eye event in the same cycle must clear the flag
	sequence eye_read_alone;
		eye_flag_q && rd_eye && !eye_low;
	endsequence

	chk_eq_index_ovr: assert property ( // R1
		lock_reg_q[rtap_pkg::EQ_OVR_BIT] |=> eq_index_q == $past(eq_idx_reg_q[4:0]))
		else $error("override index not applied");
	chk_ppm_qualify: assert property ( // R2
		lock_reg_q[rtap_pkg::PPM_EN_BIT] && !ppm_check_pass |=> !cdr_lock_q)
		else $error("lock declared with ppm check failing");
	chk_fld_mode3: assert property ( // R3
		ref_mode == rtap_pkg::REF_MODE_FLD
		|=> freq_lock_detection_q == !$past(lock_reg_q[rtap_pkg::FLD_DIS_BIT]))
		else $error("frequency-lock detection state wrong in mode 3");
	chk_adapt_selfclr: assert property ( // R4
		start_write |=> start_pulse)
		else $error("adaptation start bit did not self-clear");
	chk_eye_flag_set: assert property ( // R5
		eye_low |=> eye_flag_q)
		else $error("eye flag not set on low opening");
	chk_eye_flag_sticky: assert property ( // R6
		eye_flag_q && !rd_eye |=> eye_flag_q)
		else $error("eye flag dropped without a read");
	chk_eye_read_clear: assert property ( // R6
		eye_read_alone |=> !eye_flag_q)
		else $error("eye flag not cleared by read");
	chk_mode_none: assert property ( // R11
		state_q == rtap_pkg::AD_IDLE && adapt_start_q && ad_mode == rtap_pkg::AD_NONE
		|=> state_q == rtap_pkg::AD_IDLE ##1 !adapt_busy_q)
		else $error("adaptation ran in mode 00");
	chk_mode11_lock: assert property ( // R12
		state_q == rtap_pkg::AD_CTLE1 && ad_mode == rtap_pkg::AD_LOCK && cdr_lock_q
		|=> state_q == rtap_pkg::AD_DFE ##0 dfe_run_q && !ctle_run_q)
		else $error("mode 11 did not move to dfe on lock");
	chk_merit_invalid: assert property ( // R13
		state_q == rtap_pkg::AD_IDLE && adapt_start_q && merit == rtap_pkg::MERIT_BAD
		|=> state_q == rtap_pkg::AD_IDLE)
		else $error("adaptation started with invalid merit code");
endmodule
`default_nettype wire

/* sim/rtap_regs_tb_top.sv */
// self-checking bench for the retimer control register slice
`timescale 1ns/100ps
`default_nettype none
`define CHK(a,b) begin checks++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t got %h exp %h", $time, a, b); end end
`define WAITFOR(c) begin wn = 0; while (!(c) && wn < 200) begin @(posedge pclk); wn++; end `CHK(wn < 200, 1'b1) end
`define PULSE(s) begin s <= 1'b1; @(posedge pclk); s <= 1'b0; end
module rtap_regs_tb_top;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb, rate_ctrl_q;
	logic        pready, pslverr;
	logic [1:0]  ref_mode;
	logic        cdr_phase_lock, ppm_check_pass, freq_lock_ok, ctle_optimal, dfe_done;
	logic [4:0]  adapt_eq_index, eq_index_q;
	logic [7:0]  horizontal_eye_opening, vertical_eye_opening, rd, ridx;
	logic        eye_meas_valid, eye_monitor_range_error, pattern_rx_bit, inj, er;
	logic        cdr_lock_q, freq_lock_detection_q, ctle_run_q, dfe_run_q, adapt_busy_q;
	logic        merit_use_heo_q, merit_use_veo_q, pattern_tx_bit, pattern_err;
	int          fail_count, checks, wn, errc, regm[int];
	bit          q1[$], q2[$], q3[$];
	int          tn[4] = '{7, 9, 15, 31};
	int          tm[4] = '{6, 5, 14, 28};
	// eye cases: {enable, heo, veo}
	logic [16:0] ev[4] = '{{1'b0, 8'd4, 8'd4}, {1'b1, 8'd8, 8'd8},
		{1'b1, 8'd4, 8'd100}, {1'b1, 8'd100, 8'd7}};

	rtap_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .ref_mode, .cdr_phase_lock, .ppm_check_pass, .freq_lock_ok,
		.adapt_eq_index, .ctle_optimal, .dfe_done, .horizontal_eye_opening, .vertical_eye_opening,
		.eye_meas_valid, .eye_monitor_range_error, .pattern_rx_bit, .eq_index_q, .rate_ctrl_q,
		.cdr_lock_q, .freq_lock_detection_q, .ctle_run_q, .dfe_run_q, .adapt_busy_q,
		.merit_use_heo_q, .merit_use_veo_q, .pattern_tx_bit, .pattern_err);

	always #12.5 pclk = ~pclk;
	// serial loopback so the checker sees the generator; inj flips one bit on demand
	always @(posedge pclk) pattern_rx_bit <= pattern_tx_bit ^ inj;

	task automatic finish_test();
		if (fail_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// one apb transfer; entered just after a rising edge, leaves one idle edge behind it
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		`CHK(n < 50, 1'b1)
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
		`CHK(er, 1'b0)
		if (pstrb[0])
			regm[idx] = d;
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [7:0] mask);
		apb(1'b0, idx, 8'h00);
		`CHK({er, rd & mask}, {1'b0, regm[idx][7:0] & mask})
	endtask

	task automatic grab(ref bit q[$]);
		q = {};
		errc = 0;
		repeat (120) begin
			@(posedge pclk);
			q.push_back(pattern_tx_bit);
			errc += int'(pattern_err === 1'b1);
		end
		// first sample is the output bit held from before the restart
		void'(q.pop_front());
	endtask

	function automatic int bad(bit q[$], int n, int m);
		int c = 0;
		for (int k = n; k < q.size(); k++)
			c += int'(q[k] != (q[k-n] ^ q[k-m]));
		return c;
	endfunction

	task automatic adapt(input logic [1:0] mode, input logic [1:0] merit);
		wr(8'h31, {1'b0, mode, merit, 3'h0});
		@(posedge pclk);
		`CHK({merit_use_veo_q, merit_use_heo_q}, merit)
		wr(8'h2F, 8'h07);
		regm[8'h2F] = 8'h06;
		if (mode == rtap_pkg::AD_NONE || merit == rtap_pkg::MERIT_BAD) begin
			repeat (5) @(posedge pclk);
			`CHK(adapt_busy_q, 1'b0)
		end else begin
			`WAITFOR(ctle_run_q === 1'b1)
			`CHK({adapt_busy_q, dfe_run_q}, 2'b10)
			`PULSE(ctle_optimal)
			if (mode == rtap_pkg::AD_LOCK) begin
				repeat (3) @(posedge pclk);
				`CHK(ctle_run_q, 1'b1)
				cdr_phase_lock <= 1'b1;
			end
			if (mode != rtap_pkg::AD_CTLE) begin
				`WAITFOR(dfe_run_q === 1'b1)
				`PULSE(dfe_done)
				`WAITFOR(ctle_run_q === 1'b1)
				`PULSE(ctle_optimal)
			end
			`WAITFOR(adapt_busy_q === 1'b0)
			cdr_phase_lock <= 1'b0;
		end
		rdc(8'h2F, 8'hFF);
	endtask

	initial begin
		#(25ns * 40000);
		fail_count++;
		finish_test();
	end

	initial begin
		{pclk, psel, penable, pwrite, paddr, pwdata, inj, cdr_phase_lock, ctle_optimal} = '0;
		{dfe_done, eye_meas_valid, eye_monitor_range_error, adapt_eq_index, freq_lock_ok} = '0;
		{horizontal_eye_opening, vertical_eye_opening, ppm_check_pass} = '0;
		{pstrb, ref_mode, presetn} = {4'hF, 2'h3, 1'b0};
		regm = '{8'h13: 8'h00, 8'h2F: 8'h06, 8'h30: 8'h00, 8'h31: 8'h20, 8'h36: 8'h00, 8'h76: 8'h11};
		void'($urandom(32'hF7CF));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (regm[i])
			rdc(i[7:0], 8'hFF);
		apb(1'b0, 8'h20, 8'h00);
		`CHK({er, rd}, {1'b1, 8'h00})
		pstrb <= 4'h0;
		wr(8'h13, 8'hFF);
		pstrb <= 4'hF;
		rdc(8'h13, 8'hFF);
		// equalizer index override against the adaptation index
		ridx = 8'($urandom);
		adapt_eq_index <= 5'($urandom);
		wr(8'h13, {3'h0, ridx[4:0]});
		wr(8'h2F, {ridx[7:4], 4'hE});
		repeat (2) @(posedge pclk);
		`CHK({rate_ctrl_q, eq_index_q}, {ridx[7:4], ridx[4:0]})
		wr(8'h2F, 8'h06);
		repeat (2) @(posedge pclk);
		`CHK(eq_index_q, adapt_eq_index)
		// every combination of the lock qualifiers
		for (int i = 0; i < 32; i++) begin
			wr(8'h2F, {5'h00, i[0], i[1], 1'b0});
			ppm_check_pass <= i[2];
			freq_lock_ok <= i[3];
			cdr_phase_lock <= i[4];
			repeat (2) @(posedge pclk);
			`CHK(freq_lock_detection_q, !i[1])
			`CHK(cdr_lock_q, i[4] & (!i[0] | i[2]) & (i[1] | i[3]))
		end
		ref_mode <= 2'h0;
		repeat (2) @(posedge pclk);
		`CHK(freq_lock_detection_q, 1'b1)
		{ppm_check_pass, freq_lock_ok, cdr_phase_lock} <= 3'b110;
		for (int i = 0; i < 16; i++)
			adapt(i[3:2], i[1:0]);
		// eye flag: the first case is below the limits but not enabled; only the last two set the flag
		foreach (ev[i]) begin
			wr(8'h36, {1'b0, ev[i][16], 6'h00});
			horizontal_eye_opening <= ev[i][15:8];
			vertical_eye_opening <= ev[i][7:0];
			`PULSE(eye_meas_valid)
			repeat (4) @(posedge pclk);
			apb(1'b0, 8'h30, 8'h00);
			`CHK(rd[4], logic'(i >= 2))
			apb(1'b0, 8'h30, 8'h00);
			`CHK(rd[4], 1'b0)
		end
		eye_monitor_range_error <= 1'b1;
		apb(1'b0, 8'h30, 8'h00);
		`CHK(rd[5], 1'b1)
		// pattern engine per select code
		foreach (tn[s]) begin
			wr(8'h30, {4'h0, 1'b1, 1'b0, 2'(s)});
			grab(q1);
			`CHK(bad(q1, tn[s], tm[s]) == 0 || bad(q1, tn[s], tn[s] - tm[s]) == 0, 1'b1)
			`CHK(q1.sum() with (int'(item)) > 20, 1'b1)
			grab(q3);
			`CHK(errc, 0)
			wr(8'h30, {4'h0, 1'b0, 1'b0, 2'(s)});
			grab(q2);
			`CHK(q2.sum() with (int'(item)) % q2.size() == 0 && errc == 0, 1'b1)
			wr(8'h30, {4'h0, 1'b1, 1'b0, 2'(s)});
			grab(q3);
			`CHK(q3 == q1, 1'b1)
			`PULSE(inj)
			grab(q3);
			`CHK(errc > 0, 1'b1)
		end
		rdc(8'h30, 8'hCF);
		finish_test();
	end
endmodule
`default_nettype wire
